// ===== rtl/rfm_dev_end.sv
// Device side: register file with sets, banks, pages and pointers
//
// Notes on behaviour
// - D0H-FFH direct accesses hit set 1; C0H-CFH direct accesses are refused as illegal
// - Two banks behind E0H-FFH, selectable
// - Reset selects bank 0
// - D0H-DFH system, C0H-CFH common area
// - Set 1 via direct and working modes
// - Common area reached only by working mode
// - Set 2 per page, indirect/indexed only
// - Prime 00H-BFH per page, all modes
// - Prime accesses use page 0 after reset
// - File split into 32 eight-byte slices
// - Two pointers form a 16-byte block
// - Working access never reaches set 2
// - Pointer top five bits give slice
// - Pointers readable/writable at D6H, D7H
// - Reset pointers to C0H and C8H
// - Single pointer load leaves other intact
// - Swapped or split slices are honoured
// - Top bit picks pointer, concat low bits
// - Address 1100xxxx means working address
// - Page pointer nibbles reset to zero
`timescale 1ns/1ps
module rfm_dev_end
    import rfm_pkg::*;
#(
    parameter int PAGES = 8
)(
    input wire logic sys_clk,
    input wire logic rst_n,
    rfm_if.dev link,
    output logic bank_sel,
    output logic [7:0] page_ptr
);
    import rfm_pkg::*;
    localparam int PRIME_SZ = 192;
    localparam int SET_SZ = 64;
    localparam int BANK_SZ = 32;
    localparam int SYS_SZ = 16;
    // Index widths follow the area sizes, so a resized area stays consistent
    localparam int SET_AW = $clog2(SET_SZ);
    localparam int BANK_AW = $clog2(BANK_SZ);
    localparam int SYS_AW = $clog2(SYS_SZ);
    localparam int DEST_LO = 4;
    logic [7:0] prime_mem [PAGES][PRIME_SZ];
    logic [7:0] set2_mem [PAGES][SET_SZ];
    logic [7:0] bank_mem [2][BANK_SZ];
    logic [7:0] common_mem [SYS_SZ];
    logic [7:0] sys_mem [SYS_SZ];
    logic [7:0] wsp0_r, wsp0_nxt, wsp1_r, wsp1_nxt, pp_r, pp_nxt;
    logic bank_r, bank_nxt;
    logic [7:0] rdata_r, rdata_nxt, paddr_r, paddr_nxt;
    logic [PAGE_W-1:0] ppage_r, ppage_nxt;
    rfm_region_t region_r, region_nxt;
    logic ack_r, ack_nxt;
    logic wr_go;
    logic [7:0] eff;
    logic [PAGE_W-1:0] page;
    rfm_region_t reg_c;

    // One write strobe shared by pointer flops and storage
    assign wr_go = link.req && link.wr;

    function automatic logic [7:0] work_addr(input logic [3:0] wa,
        input logic [7:0] p0, input logic [7:0] p1);
        logic [7:0] p;
        p = wa[WSEL_BIT] ? p1 : p0;
        return {p[SLICE_HI:SLICE_LO], wa[SLICE_LO-1:0]};
    endfunction

    // Resolve effective address, page and region
    always_comb begin
        eff = link.addr;
        page = pp_r[PAGE_W-1:0];
        reg_c = RFM_REG_PRIME;
        unique case (link.mode)
            RFM_MODE_WORK4:
                eff = work_addr(link.addr[3:0], wsp0_r, wsp1_r);
            RFM_MODE_WORK8:
                if (link.addr[7:4] == WORK8_PREFIX)
                    eff = work_addr(link.addr[3:0], wsp0_r, wsp1_r);
            default: eff = link.addr;
        endcase
        // Reads take the source nibble, writes the destination nibble
        if (link.wr)
            page = pp_r[DEST_LO+PAGE_W-1:DEST_LO];
        // Working modes never select set 2, so C0H-FFH stays in set 1
        if (eff < SET1_BASE) begin
            reg_c = RFM_REG_PRIME;
        end else if (link.mode == RFM_MODE_INDIRECT ||
                     link.mode == RFM_MODE_INDEXED) begin
            reg_c = RFM_REG_SET2;
        end else if (link.mode == RFM_MODE_DIRECT &&
                     eff <= COMMON_TOP) begin
            reg_c = RFM_REG_ILLEGAL;
        end else if (eff >= BANKED_BASE) begin
            reg_c = bank_r ? RFM_REG_BANK1 : RFM_REG_BANK0;
        end else if (eff >= SYSREG_BASE) begin
            reg_c = RFM_REG_SYSTEM;
        end else begin
            reg_c = RFM_REG_COMMON;
        end
    end

    // Pointer, bank and page pointer next state
    always_comb begin
        wsp0_nxt = wsp0_r;
        wsp1_nxt = wsp1_r;
        pp_nxt = pp_r;
        bank_nxt = bank_r;
        unique case (link.cmd)
            RFM_CMD_SET_BOTH: begin
                wsp0_nxt = link.cmd_val;
                wsp1_nxt = link.cmd_val + PAIR_STEP;
            end
            RFM_CMD_SET_FIRST: wsp0_nxt = link.cmd_val;
            RFM_CMD_SET_SECOND: wsp1_nxt = link.cmd_val;
            RFM_CMD_BANK0: bank_nxt = 1'b0;
            RFM_CMD_BANK1: bank_nxt = 1'b1;
            default: ;
        endcase
        if (wr_go && reg_c == RFM_REG_SYSTEM) begin
            if (eff == WSP_FIRST_ADDR) wsp0_nxt = link.wdata;
            if (eff == WSP_SECOND_ADDR) wsp1_nxt = link.wdata;
            if (eff == PAGE_PTR_ADDR) pp_nxt = link.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wsp0_r <= WSP_FIRST_RST;
            wsp1_r <= WSP_SECOND_RST;
            pp_r <= PAGE_PTR_RST;
            bank_r <= 1'b0;
        end else begin
            wsp0_r <= wsp0_nxt;
            wsp1_r <= wsp1_nxt;
            pp_r <= pp_nxt;
            bank_r <= bank_nxt;
        end
    end

    // Storage; pointer and page registers live in flops, not the array
    // No reset on storage: contents stay unknown until first written
    always_ff @(posedge sys_clk) begin
        if (wr_go) begin
            unique case (reg_c)
                RFM_REG_PRIME: prime_mem[page][eff] <= link.wdata;
                RFM_REG_SET2: set2_mem[page][eff[SET_AW-1:0]] <= link.wdata;
                RFM_REG_BANK0: bank_mem[0][eff[BANK_AW-1:0]] <= link.wdata;
                RFM_REG_BANK1: bank_mem[1][eff[BANK_AW-1:0]] <= link.wdata;
                RFM_REG_COMMON: common_mem[eff[SYS_AW-1:0]] <= link.wdata;
                RFM_REG_SYSTEM: sys_mem[eff[SYS_AW-1:0]] <= link.wdata;
                default: ;
            endcase
        end
    end

    // Answer path: capture map result and read data of each access
    always_comb begin
        ack_nxt = link.req;
        rdata_nxt = rdata_r;
        paddr_nxt = paddr_r;
        ppage_nxt = ppage_r;
        region_nxt = region_r;
        if (link.req) begin
            paddr_nxt = eff;
            ppage_nxt = page;
            region_nxt = reg_c;
            unique case (reg_c)
                RFM_REG_PRIME: rdata_nxt = prime_mem[page][eff];
                RFM_REG_SET2: rdata_nxt = set2_mem[page][eff[SET_AW-1:0]];
                RFM_REG_BANK0: rdata_nxt = bank_mem[0][eff[BANK_AW-1:0]];
                RFM_REG_BANK1: rdata_nxt = bank_mem[1][eff[BANK_AW-1:0]];
                RFM_REG_COMMON: rdata_nxt = common_mem[eff[SYS_AW-1:0]];
                RFM_REG_SYSTEM:
                    rdata_nxt = eff == WSP_FIRST_ADDR ? wsp0_r :
                        eff == WSP_SECOND_ADDR ? wsp1_r :
                        eff == PAGE_PTR_ADDR ? pp_r :
                        sys_mem[eff[SYS_AW-1:0]];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
            paddr_r <= 8'h00;
            ppage_r <= '0;
            region_r <= RFM_REG_PRIME;
            ack_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            paddr_r <= paddr_nxt;
            ppage_r <= ppage_nxt;
            region_r <= region_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign link.rdata = rdata_r;
    assign link.phys_addr = paddr_r;
    assign link.phys_page = ppage_r;
    assign link.region = region_r;
    assign link.ack = ack_r;
    assign bank_sel = bank_r;
    assign page_ptr = pp_r;
endmodule

// ===== rtl/rfm_pkg.sv
// Package with register file map constants and access types
package rfm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 3;
    localparam logic [7:0] SET1_BASE = 8'hc0;
    localparam logic [7:0] BANKED_BASE = 8'he0;
    localparam logic [7:0] SYSREG_BASE = 8'hd0;
    localparam logic [7:0] COMMON_TOP = 8'hcf;
    localparam logic [7:0] WSP_FIRST_ADDR = 8'hd6;
    localparam logic [7:0] WSP_SECOND_ADDR = 8'hd7;
    localparam logic [7:0] PAGE_PTR_ADDR = 8'hdf;
    localparam logic [7:0] WSP_FIRST_RST = 8'hc0;
    localparam logic [7:0] WSP_SECOND_RST = 8'hc8;
    localparam logic [7:0] PAGE_PTR_RST = 8'h00;
    localparam logic [7:0] PAIR_STEP = 8'h08;
    localparam logic [3:0] WORK8_PREFIX = 4'hc;
    localparam int SLICE_HI = 7;
    localparam int SLICE_LO = 3;
    localparam int WSEL_BIT = 3;
    // Access modes the core may request
    typedef enum logic [2:0] {
        RFM_MODE_DIRECT,
        RFM_MODE_INDIRECT,
        RFM_MODE_INDEXED,
        RFM_MODE_WORK4,
        RFM_MODE_WORK8
    } rfm_mode_t;
    // Pointer load and bank select commands
    typedef enum logic [2:0] {
        RFM_CMD_NONE,
        RFM_CMD_SET_BOTH,
        RFM_CMD_SET_FIRST,
        RFM_CMD_SET_SECOND,
        RFM_CMD_BANK0,
        RFM_CMD_BANK1
    } rfm_cmd_t;
    // Resolved region of an access
    typedef enum logic [2:0] {
        RFM_REG_PRIME,
        RFM_REG_COMMON,
        RFM_REG_SYSTEM,
        RFM_REG_BANK0,
        RFM_REG_BANK1,
        RFM_REG_SET2,
        RFM_REG_ILLEGAL
    } rfm_region_t;
endpackage

// ===== rtl/rfm_if.sv
// Interface between the core addressing logic and the register file map
`timescale 1ns/1ps
interface rfm_if;
    import rfm_pkg::*;
    logic req;
    logic wr;
    rfm_mode_t mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    rfm_cmd_t cmd;
    logic [DATA_W-1:0] cmd_val;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] phys_addr;
    logic [PAGE_W-1:0] phys_page;
    rfm_region_t region;
    logic ack;
    modport dev (input req, wr, mode, addr, wdata, cmd, cmd_val,
        output rdata, phys_addr, phys_page, region, ack);
    modport core (output req, wr, mode, addr, wdata, cmd, cmd_val,
        input rdata, phys_addr, phys_page, region, ack);
endinterface

// ===== rtl/rfm_core_end.sv
// Core side: software command port turned into map accesses
`timescale 1ns/1ps
module rfm_core_end
    import rfm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    rfm_if.core link,
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata
);
    import rfm_pkg::*;
    // Software regs: 0 mode, 1 address, 2 data/go write, 3 command go
    localparam logic [3:0] SW_MODE = 4'h0;
    localparam logic [3:0] SW_ADDR = 4'h1;
    localparam logic [3:0] SW_DATA = 4'h2;
    localparam logic [3:0] SW_CMD = 4'h3;
    localparam logic [3:0] SW_RESULT = 4'h4;
    localparam logic [3:0] SW_PHYS = 4'h5;
    localparam logic [3:0] SW_INFO = 4'h6;
    logic [7:0] mode_r, mode_nxt, addr_r, addr_nxt, res_r, res_nxt;
    logic [7:0] phys_r, phys_nxt, info_r, info_nxt, rd_r, rd_nxt;
    always_comb begin
        mode_nxt = mode_r;
        addr_nxt = addr_r;
        res_nxt = res_r;
        phys_nxt = phys_r;
        info_nxt = info_r;
        rd_nxt = 8'h00;
        if (sw_wr && sw_addr == SW_MODE) mode_nxt = sw_wdata;
        if (sw_wr && sw_addr == SW_ADDR) addr_nxt = sw_wdata;
        if (link.ack) begin
            res_nxt = link.rdata;
            phys_nxt = link.phys_addr;
            info_nxt = {2'b00, link.phys_page, link.region};
        end
        if (sw_rd) begin
            unique case (sw_addr)
                SW_MODE: rd_nxt = mode_r;
                SW_ADDR: rd_nxt = addr_r;
                SW_RESULT: rd_nxt = res_r;
                SW_PHYS: rd_nxt = phys_r;
                SW_INFO: rd_nxt = info_r;
                default: rd_nxt = 8'h00;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= 8'h00;
            addr_r <= 8'h00;
            res_r <= 8'h00;
            phys_r <= 8'h00;
            info_r <= 8'h00;
            rd_r <= 8'h00;
        end else begin
            mode_r <= mode_nxt;
            addr_r <= addr_nxt;
            res_r <= res_nxt;
            phys_r <= phys_nxt;
            info_r <= info_nxt;
            rd_r <= rd_nxt;
        end
    end
    assign sw_rdata = rd_r;
    // Writes to DATA issue a write, reads of DATA issue a read
    assign link.req = (sw_wr || sw_rd) && sw_addr == SW_DATA;
    assign link.wr = sw_wr;
    assign link.mode = rfm_mode_t'(mode_r[2:0]);
    assign link.addr = addr_r;
    assign link.wdata = sw_wdata;
    // Command register: low three bits pick command, value from ADDR
    assign link.cmd = (sw_wr && sw_addr == SW_CMD)
        ? rfm_cmd_t'(sw_wdata[2:0]) : RFM_CMD_NONE;
    assign link.cmd_val = addr_r;
endmodule

// ===== verification/rfm_chk.sv
// Checker for the link between core end and device end
`timescale 1ns/1ps
module rfm_chk
    import rfm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic wr,
    input rfm_mode_t mode,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input rfm_cmd_t cmd,
    input wire logic [7:0] cmd_val,
    input wire logic [7:0] phys_addr,
    input rfm_region_t region
);
    logic [7:0] p0_r, p1_r, p0_nxt, p1_nxt, wsel, wexp;
    logic bank_r, bank_nxt, dw;
    // Shadow of pointers and bank, so address checks need no design peeking
    always_comb begin
        dw = req && wr && (mode == RFM_MODE_DIRECT ||
            (mode == RFM_MODE_WORK8 && addr[7:4] != 4'hc));
        p0_nxt = p0_r;
        p1_nxt = p1_r;
        bank_nxt = bank_r;
        case (cmd)
            RFM_CMD_SET_BOTH: begin
                p0_nxt = cmd_val;
                p1_nxt = cmd_val + 8'h08;
            end
            RFM_CMD_SET_FIRST: p0_nxt = cmd_val;
            RFM_CMD_SET_SECOND: p1_nxt = cmd_val;
            RFM_CMD_BANK0: bank_nxt = 1'b0;
            RFM_CMD_BANK1: bank_nxt = 1'b1;
            default: ;
        endcase
        if (dw && addr == 8'hd6) p0_nxt = wdata;
        if (dw && addr == 8'hd7) p1_nxt = wdata;
        wsel = addr[3] ? p1_r : p0_r;
        wexp = {wsel[7:3], addr[2:0]};
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            p0_r <= 8'hc0;
            p1_r <= 8'hc8;
            bank_r <= 1'b0;
        end else begin
            p0_r <= p0_nxt;
            p1_r <= p1_nxt;
            bank_r <= bank_nxt;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_work4_addr: assert property (req && mode == RFM_MODE_WORK4
        |=> phys_addr == $past(wexp)) else $error("work4 address wrong");
    a_work8_addr: assert property (req && mode == RFM_MODE_WORK8
        && addr[7:4] == 4'hc |=> phys_addr == $past(wexp))
        else $error("work8 address wrong");
    a_work_no_set2: assert property (req && (mode == RFM_MODE_WORK4
        || mode == RFM_MODE_WORK8) |=> region != RFM_REG_SET2)
        else $error("working access hit set 2");
    a_bank_route: assert property (req && mode == RFM_MODE_DIRECT
        && addr >= 8'he0 |=> region == ($past(bank_r) ? RFM_REG_BANK1
        : RFM_REG_BANK0)) else $error("bank region wrong");
    a_common_refused: assert property (req && mode == RFM_MODE_DIRECT
        && addr[7:4] == 4'hc |=> region == RFM_REG_ILLEGAL)
        else $error("direct common access not refused");
    a_sysreg_route: assert property (req && mode == RFM_MODE_DIRECT
        && addr[7:4] == 4'hd |=> region == RFM_REG_SYSTEM)
        else $error("system region wrong");
    a_set2_route: assert property (req && addr >= 8'hc0
        && (mode == RFM_MODE_INDIRECT || mode == RFM_MODE_INDEXED)
        |=> region == RFM_REG_SET2) else $error("set 2 region wrong");
    a_prime_route: assert property (req && addr < 8'hc0
        && mode != RFM_MODE_WORK4 |=> region == RFM_REG_PRIME
        && phys_addr == $past(addr)) else $error("prime access wrong");
endmodule

// ===== verification/register_file_map_working_pointers_tb.sv
// Testbench driving both ends through the software port
`timescale 1ns/1ps
module register_file_map_working_pointers_tb;
    import rfm_pkg::*;
    logic sys_clk, rst_n, sw_wr, sw_rd, bank_sel;
    logic [3:0] sw_addr;
    logic [7:0] sw_wdata, sw_rdata, page_ptr, v, info;
    int miscompares = 0, samples_checked = 0, cyc = 0;
    rfm_if lnk();
    rfm_core_end rfm_core_end_inst(.sys_clk(sys_clk), .rst_n(rst_n),
        .link(lnk), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    rfm_dev_end rfm_dev_end_inst(.sys_clk(sys_clk), .rst_n(rst_n),
        .link(lnk), .bank_sel(bank_sel), .page_ptr(page_ptr));
    rfm_chk rfm_chk_inst(.sys_clk(sys_clk), .rst_n(rst_n), .req(lnk.req),
        .wr(lnk.wr), .mode(lnk.mode), .addr(lnk.addr), .wdata(lnk.wdata),
        .cmd(lnk.cmd), .cmd_val(lnk.cmd_val), .phys_addr(lnk.phys_addr),
        .region(lnk.region));
    initial begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // Gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge sys_clk);
        sw_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge sys_clk);
        sw_rd <= 1'b0;
        @(posedge sys_clk);
        d = sw_rdata;
    endtask
    task automatic cm(input rfm_cmd_t c, input logic [7:0] val);
        wr(4'h1, val);
        wr(4'h3, {5'h0, c});
    endtask
    task automatic acc(input rfm_mode_t m, input logic [7:0] a, input logic w,
        input logic [7:0] d, input logic [7:0] ep, input rfm_region_t er);
        wr(4'h0, {5'h0, m});
        wr(4'h1, a);
        if (w) wr(4'h2, d);
        else rd(4'h2, v);
        repeat (4) @(posedge sys_clk);
        rd(4'h5, v);
        chk(v, ep);
        rd(4'h6, info);
        chk({5'h0, info[2:0]}, {5'h0, er});
        rd(4'h4, v);
    endtask
    initial begin
        {rst_n, sw_wr, sw_rd, sw_addr, sw_wdata} = '0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        acc(RFM_MODE_DIRECT, 8'hd6, 0, 0, 8'hd6, RFM_REG_SYSTEM);
        chk(v, 8'hc0);
        acc(RFM_MODE_DIRECT, 8'hd7, 0, 0, 8'hd7, RFM_REG_SYSTEM);
        chk(v, 8'hc8);
        acc(RFM_MODE_DIRECT, 8'hdf, 0, 0, 8'hdf, RFM_REG_SYSTEM);
        chk(v, 8'h00);
        acc(RFM_MODE_WORK4, 8'h06, 0, 0, 8'hc6, RFM_REG_COMMON);
        acc(RFM_MODE_WORK4, 8'h0f, 0, 0, 8'hcf, RFM_REG_COMMON);
        acc(RFM_MODE_DIRECT, 8'hc2, 0, 0, 8'hc2, RFM_REG_ILLEGAL);
        chk(v, 8'h00);
        cm(RFM_CMD_SET_BOTH, 8'h70);
        acc(RFM_MODE_WORK4, 8'h06, 0, 0, 8'h76, RFM_REG_PRIME);
        acc(RFM_MODE_WORK4, 8'h0b, 0, 0, 8'h7b, RFM_REG_PRIME);
        cm(RFM_CMD_SET_SECOND, 8'h48);
        acc(RFM_MODE_WORK4, 8'h09, 0, 0, 8'h49, RFM_REG_PRIME);
        acc(RFM_MODE_WORK4, 8'h01, 0, 0, 8'h71, RFM_REG_PRIME);
        cm(RFM_CMD_SET_FIRST, 8'ha0);
        acc(RFM_MODE_WORK4, 8'h02, 1, 8'h5a, 8'ha2, RFM_REG_PRIME);
        acc(RFM_MODE_DIRECT, 8'ha2, 0, 0, 8'ha2, RFM_REG_PRIME);
        chk(v, 8'h5a);
        acc(RFM_MODE_DIRECT, 8'hd7, 1, 8'hf8, 8'hd7, RFM_REG_SYSTEM);
        acc(RFM_MODE_DIRECT, 8'hd6, 0, 0, 8'hd6, RFM_REG_SYSTEM);
        chk(v, 8'ha0);
        acc(RFM_MODE_WORK8, 8'hd6, 0, 0, 8'hd6, RFM_REG_SYSTEM);
        chk(v, 8'ha0);
        acc(RFM_MODE_WORK8, 8'hca, 0, 0, 8'hfa, RFM_REG_BANK0);
        acc(RFM_MODE_DIRECT, 8'he5, 1, 8'h11, 8'he5, RFM_REG_BANK0);
        cm(RFM_CMD_BANK1, 8'h00);
        chk({7'h0, bank_sel}, 8'h01);
        acc(RFM_MODE_DIRECT, 8'he5, 1, 8'h22, 8'he5, RFM_REG_BANK1);
        acc(RFM_MODE_WORK8, 8'hcd, 0, 0, 8'hfd, RFM_REG_BANK1);
        cm(RFM_CMD_BANK0, 8'h00);
        acc(RFM_MODE_DIRECT, 8'he5, 0, 0, 8'he5, RFM_REG_BANK0);
        chk(v, 8'h11);
        acc(RFM_MODE_INDIRECT, 8'hc5, 1, 8'h33, 8'hc5, RFM_REG_SET2);
        acc(RFM_MODE_INDEXED, 8'hc5, 0, 0, 8'hc5, RFM_REG_SET2);
        chk(v, 8'h33);
        acc(RFM_MODE_DIRECT, 8'hdf, 1, 8'h10, 8'hdf, RFM_REG_SYSTEM);
        acc(RFM_MODE_INDIRECT, 8'h40, 1, 8'h77, 8'h40, RFM_REG_PRIME);
        chk({5'h0, info[5:3]}, 8'h01);
        acc(RFM_MODE_INDIRECT, 8'h40, 0, 0, 8'h40, RFM_REG_PRIME);
        chk({5'h0, info[5:3]}, 8'h00);
        acc(RFM_MODE_DIRECT, 8'hdf, 1, 8'h11, 8'hdf, RFM_REG_SYSTEM);
        acc(RFM_MODE_INDIRECT, 8'h40, 0, 0, 8'h40, RFM_REG_PRIME);
        chk(v, 8'h77);
        chk(page_ptr, 8'h11);
        report_and_stop();
    end
endmodule
